/* File: verilog/pms_cfg.svh */
// constants for the programming-model state block
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define PMS_OP_ADDI 6'h0e
`define PMS_OP_SC 6'h11
`define PMS_OP_B 6'h12
`define PMS_OP_19 6'h13
`define PMS_OP_X 6'h1f
`define PMS_OP_LWZ 6'h20
`define PMS_OP_STW 6'h24
`define PMS_OP_LFS 6'h30
`define PMS_OP_LFD 6'h32
`define PMS_OP_STFS 6'h34
`define PMS_OP_STFD 6'h36
`define PMS_OP_FPS 6'h3b
`define PMS_OP_FPD 6'h3f
`define PMS_XO_FCMPU 10'h000
`define PMS_XO_FRSP 10'h00c
`define PMS_XO_LWZX 10'h017
`define PMS_XO_RFI 10'h032
`define PMS_XO_MFMSR 10'h053
`define PMS_XO_MTMSR 10'h092
`define PMS_XO_ISYNC 10'h096
`define PMS_XO_STWX 10'h097
`define PMS_XO_ADD 10'h10a
`define PMS_XO_MFSPR 10'h153
`define PMS_XO_MFTB 10'h173
`define PMS_XO_MTSPR 10'h1d3
`define PMS_XO_SYNC 10'h256
`define PMS_XO_EIEIO 10'h356
`define PMS_XO_ICBI 10'h3d6
`define PMS_XO_STFIWX 10'h3d7
`define PMS_SPR_XER 10'h001
`define PMS_SPR_SAVE_RESTORE_ADDRESS_REG 10'h01a
`define PMS_SPR_SAVE_RESTORE_STATE_REG 10'h01b
`define PMS_SPR_TBL 10'h10c
`define PMS_SPR_TBU 10'h10d
`define PMS_SPR_SUPER 4
`define PMS_VEC_PROG 32'h00000700
`define PMS_VEC_SC 32'h00000c00
`define PMS_VEC_EMU 32'h00001000
`define PMS_RESET_PC 32'h00000100
`define PMS_INSTR_BYTES 32'h00000004
`define PMS_MSR_PR 14
`define PMS_MSR_MASK 32'h0000fff3
`define PMS_MSR_RESET 32'h00000000
`define PMS_XER_MASK 32'he000ff7f
`define PMS_FLOAT_STATUS_CONTROL_REG_FX 31
`define PMS_FLOAT_STATUS_CONTROL_REG_XX 25
`define PMS_FLOAT_STATUS_CONTROL_REG_FI 17
`define PMS_FLOAT_STATUS_CONTROL_REG_FPCC 12
`define PMS_EXP_ADJ 11'h380
`endif

/* File: verilog/pms_pkg.sv */
// types for the programming-model state block
package pms_pkg;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_MEM = 2'b01
  } pms_state_e;
  typedef enum logic [1:0] {
    LD_NONE = 2'b00,
    LD_GPR = 2'b01,
    LD_FS = 2'b11,
    LD_FD = 2'b10
  } pms_load_e;
  typedef struct packed {
    logic req;
    logic we;
    logic dbl;
    logic [31:0] addr;
    logic [63:0] wdata;
  } pms_mem_s;
endpackage

/* File: verilog/pms_core.sv */
// programming-model state: register files, address forming, exceptions
// Notes on behaviour
// - 32-bit address for access, branch, fetch
// - base plus immediate or index; zero base reads 0
// - zero immediate gives base alone
// - unimplemented optional op takes emulation trap
// - decode only defined ops; store-as-int-word optional
// - required, sync, cache, time-base, supervisor ops
// - exception saves return address and state
// - exceptions serviced strictly in program order
// - older instructions finish before taking exception
// - one exception at a time
// - supervisor ops only at supervisor level
// - privilege bit shown; exceptions enter supervisor
// - reserved bits read zero, except stored byte
// - thirty-two 32-bit integer registers
// - thirty-two 64-bit float registers, double format
// - float results to register, compares to condition
// - double load and store unconverted
// - single load widens, single store narrows
// - round intermediate to destination, store as double
`timescale 1ns/1ns
`include "pms_cfg.svh"
module pms_core import pms_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  output logic issue_ready,
  output logic [31:0] fetch_addr,
  // memory access
  output pms_mem_s mem_out,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  // architectural state
  output logic exc_taken,
  output logic [31:0] machine_state_register,
  output logic [31:0] condition_register,
  output logic [31:0] float_status_control_reg
);
  logic [31:0] integer_register [32];
  logic [63:0] float_register [32];
  pms_state_e state, next_state;
  pms_load_e pend, next_pend;
  logic [4:0] pend_rd, next_pend_rd;
  pms_mem_s next_mem;
  logic next_ready, next_exc;
  logic [31:0] next_pc, next_msr, next_cr, next_float_status_control_reg;
  logic [31:0] save_restore_address_reg, next_save_restore_address_reg;
  logic [31:0] save_restore_state_reg, next_save_restore_state_reg;
  logic [31:0] integer_exception_register, next_xer;
  logic [63:0] tb, next_tb;
  logic gpr_we, fpr_we;
  logic [4:0] gpr_wa, fpr_wa;
  logic [31:0] gpr_wd;
  logic [63:0] fpr_wd;
  logic [5:0] op;
  logic [4:0] rd, ra, rb;
  logic [9:0] xo, spr;
  logic [2:0] bf;
  logic [31:0] base_register_operand, index_register_operand, disp;
  logic [31:0] ea_d, ea_x;
  logic go, pr, trap;
  logic [31:0] vec, ret;
  logic [32:0] narrow, narrow_st;
  logic [3:0] cmp;

  // single to double is exact; denormals are normalised
  function automatic logic [63:0] pms_s2d(input logic [31:0] s);
    logic [10:0] e;
    logic [23:0] mm;
    e = {3'h0, s[30:23]} + `PMS_EXP_ADJ;
    mm = {1'b0, s[22:0]};
    if (s[30:23] == 8'hff) begin
      return {s[31], 11'h7ff, s[22:0], 29'h0};
    end
    if (s[30:0] == 31'h0) begin
      return {s[31], 63'h0};
    end
    if (s[30:23] == 8'h00) begin
      e = `PMS_EXP_ADJ + 11'h001;
      for (int i = 0; i < 23; i++) begin
        if (!mm[23]) begin
          mm = {mm[22:0], 1'b0};
          e = e - 11'h001;
        end
      end
    end
    return {s[31], e, mm[22:0], 29'h0};
  endfunction

  // round to nearest even; tiny results flush to signed zero
  function automatic logic [32:0] pms_d2s(input logic [63:0] d);
    logic signed [12:0] ue;
    logic g, st;
    logic [31:0] r;
    ue = $signed({2'b00, d[62:52]}) - $signed({2'b00, `PMS_EXP_ADJ});
    g = d[28];
    st = |d[27:0];
    if (d[62:52] == 11'h7ff) begin
      return {1'b0, d[63], 8'hff, d[51:29] | {(|d[51:0]), 22'h0}};
    end
    if (ue >= 13'sh0ff) begin
      return {1'b1, d[63], 8'hff, 23'h0};
    end
    if (ue <= 13'sh000) begin
      return {|d[62:0], d[63], 31'h0};
    end
    r = {d[63], ue[7:0], d[51:29]};
    r[30:0] = r[30:0] + {30'h0, g & (st | d[29])};
    return {g | st, r};
  endfunction

  // less, greater, equal, unordered as a condition field
  function automatic logic [3:0] pms_fcmp(input logic [63:0] a, input logic [63:0] b);
    logic lt;
    if ((&a[62:52] && |a[51:0]) || (&b[62:52] && |b[51:0])) begin
      return 4'h1;
    end
    if (a == b || (a[62:0] == 63'h0 && b[62:0] == 63'h0)) begin
      return 4'h2;
    end
    if (a[63] != b[63]) begin
      lt = a[63];
    end else begin
      lt = a[63] ? (a[62:0] > b[62:0]) : (a[62:0] < b[62:0]);
    end
    return lt ? 4'h8 : 4'h4;
  endfunction

  assign op = instr[31:26];
  assign rd = instr[25:21];
  assign ra = instr[20:16];
  assign rb = instr[15:11];
  assign bf = instr[25:23];
  assign xo = instr[10:1];
  assign spr = {instr[15:11], instr[20:16]};
  assign pr = machine_state_register[`PMS_MSR_PR];
  assign go = instr_valid & issue_ready;
  assign base_register_operand = (ra == 5'h00) ? 32'h0 : integer_register[ra];
  assign index_register_operand = integer_register[rb];
  assign disp = {{16{instr[15]}}, instr[15:0]};
  assign ea_d = base_register_operand + disp;
  assign ea_x = base_register_operand + index_register_operand;
  assign narrow = pms_d2s(float_register[rb]);
  assign narrow_st = pms_d2s(float_register[rd]);
  assign cmp = pms_fcmp(float_register[ra], float_register[rb]);

  always_comb begin
    next_state = state;
    next_pend = pend;
    next_pend_rd = pend_rd;
    next_mem = mem_out;
    next_pc = fetch_addr;
    next_msr = machine_state_register;
    next_cr = condition_register;
    next_float_status_control_reg = float_status_control_reg;
    next_save_restore_address_reg = save_restore_address_reg;
    next_save_restore_state_reg = save_restore_state_reg;
    next_xer = integer_exception_register;
    next_tb = tb + 64'h1;
    next_exc = 1'b0;
    gpr_we = 1'b0;
    gpr_wa = rd;
    gpr_wd = 32'h0;
    fpr_we = 1'b0;
    fpr_wa = rd;
    fpr_wd = 64'h0;
    trap = 1'b0;
    vec = `PMS_VEC_PROG;
    ret = fetch_addr;
    case (state)
      ST_RUN: begin
        if (go) begin
          next_pc = fetch_addr + `PMS_INSTR_BYTES;
          next_pend_rd = rd;
          case (op)
            `PMS_OP_ADDI: begin
              gpr_we = 1'b1;
              gpr_wd = ea_d;
            end
            `PMS_OP_LWZ: begin
              next_mem = {1'b1, 1'b0, 1'b0, ea_d, 64'h0};
              next_pend = LD_GPR;
            end
            `PMS_OP_STW: begin
              next_mem = {1'b1, 1'b1, 1'b0, ea_d, 32'h0, integer_register[rd]};
              next_pend = LD_NONE;
            end
            `PMS_OP_LFS: begin
              next_mem = {1'b1, 1'b0, 1'b0, ea_d, 64'h0};
              next_pend = LD_FS;
            end
            `PMS_OP_LFD: begin
              next_mem = {1'b1, 1'b0, 1'b1, ea_d, 64'h0};
              next_pend = LD_FD;
            end
            `PMS_OP_STFS: begin
              next_mem = {1'b1, 1'b1, 1'b0, ea_d, 32'h0, narrow_st[31:0]};
              next_pend = LD_NONE;
            end
            `PMS_OP_STFD: begin
              next_mem = {1'b1, 1'b1, 1'b1, ea_d, float_register[rd]};
              next_pend = LD_NONE;
            end
            `PMS_OP_SC: begin
              trap = 1'b1;
              vec = `PMS_VEC_SC;
              ret = fetch_addr + `PMS_INSTR_BYTES;
            end
            `PMS_OP_B: begin
              next_pc = (instr[1] ? 32'h0 : fetch_addr) + {{6{instr[25]}}, instr[25:2], 2'b00};
            end
            `PMS_OP_19: begin
              if (xo == `PMS_XO_RFI) begin
                if (pr) begin
                  trap = 1'b1;
                end else begin
                  next_msr = save_restore_state_reg & `PMS_MSR_MASK;
                  next_pc = save_restore_address_reg;
                end
              end else if (xo != `PMS_XO_ISYNC) begin
                trap = 1'b1;
              end
            end
            `PMS_OP_X: begin
              case (xo)
                `PMS_XO_ADD: begin
                  gpr_we = 1'b1;
                  gpr_wd = integer_register[ra] + integer_register[rb];
                end
                `PMS_XO_LWZX: begin
                  next_mem = {1'b1, 1'b0, 1'b0, ea_x, 64'h0};
                  next_pend = LD_GPR;
                end
                `PMS_XO_STWX: begin
                  next_mem = {1'b1, 1'b1, 1'b0, ea_x, 32'h0, integer_register[rd]};
                  next_pend = LD_NONE;
                end
                `PMS_XO_STFIWX: begin
                  next_mem = {1'b1, 1'b1, 1'b0, ea_x, 32'h0, float_register[rd][31:0]};
                  next_pend = LD_NONE;
                end
                `PMS_XO_MFMSR, `PMS_XO_MTMSR: begin
                  if (pr) begin
                    trap = 1'b1;
                  end else if (xo == `PMS_XO_MFMSR) begin
                    gpr_we = 1'b1;
                    gpr_wd = machine_state_register;
                  end else begin
                    next_msr = integer_register[rd] & `PMS_MSR_MASK;
                  end
                end
                `PMS_XO_MFSPR, `PMS_XO_MTSPR: begin
                  if (pr && spr[`PMS_SPR_SUPER]) begin
                    trap = 1'b1;
                  end else if (xo == `PMS_XO_MTSPR) begin
                    case (spr)
                      `PMS_SPR_XER: next_xer = integer_register[rd] & `PMS_XER_MASK;
                      `PMS_SPR_SAVE_RESTORE_ADDRESS_REG: next_save_restore_address_reg = integer_register[rd];
                      `PMS_SPR_SAVE_RESTORE_STATE_REG: next_save_restore_state_reg = integer_register[rd];
                      default: trap = 1'b1;
                    endcase
                  end else begin
                    gpr_we = 1'b1;
                    case (spr)
                      `PMS_SPR_XER: gpr_wd = integer_exception_register;
                      `PMS_SPR_SAVE_RESTORE_ADDRESS_REG: gpr_wd = save_restore_address_reg;
                      `PMS_SPR_SAVE_RESTORE_STATE_REG: gpr_wd = save_restore_state_reg;
                      default: trap = 1'b1;
                    endcase
                  end
                end
                `PMS_XO_MFTB: begin
                  gpr_we = 1'b1;
                  case (spr)
                    `PMS_SPR_TBL: gpr_wd = tb[31:0];
                    `PMS_SPR_TBU: gpr_wd = tb[63:32];
                    default: trap = 1'b1;
                  endcase
                end
                `PMS_XO_SYNC, `PMS_XO_EIEIO, `PMS_XO_ICBI: begin
                  // ordering is already strict here, so these retire at once
                  next_pc = fetch_addr + `PMS_INSTR_BYTES;
                end
                default: trap = 1'b1;
              endcase
            end
            `PMS_OP_FPS, `PMS_OP_FPD: begin
              if (op == `PMS_OP_FPD && xo == `PMS_XO_FCMPU) begin
                next_cr = (condition_register & ~(32'hf0000000 >> {bf, 2'b00}))
                          | ({cmp, 28'h0} >> {bf, 2'b00});
                next_float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_FPCC +: 4] = cmp;
              end else if (op == `PMS_OP_FPD && xo == `PMS_XO_FRSP) begin
                fpr_we = 1'b1;
                fpr_wd = pms_s2d(narrow[31:0]);
                next_float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_FI] = narrow[32];
                next_float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_XX] = float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_XX] | narrow[32];
                next_float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_FX] = float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_FX]
                  | (narrow[32] & ~float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_XX]);
              end else begin
                trap = 1'b1;
                vec = `PMS_VEC_EMU;
              end
            end
            default: trap = 1'b1;
          endcase
          if (trap) begin
            // a faulting instruction leaves no other trace
            gpr_we = 1'b0;
            fpr_we = 1'b0;
            next_mem = mem_out;
            next_pend = pend;
            next_cr = condition_register;
            next_float_status_control_reg = float_status_control_reg;
            next_xer = integer_exception_register;
            next_save_restore_address_reg = ret;
            next_save_restore_state_reg = machine_state_register;
            next_msr = machine_state_register;
            next_msr[`PMS_MSR_PR] = 1'b0;
            next_pc = vec;
            next_exc = 1'b1;
          end
          next_state = next_mem.req ? ST_MEM : ST_RUN;
        end
      end
      ST_MEM: begin
        // no issue until the access retires, so faults stay in order
        if (mem_ack) begin
          next_mem.req = 1'b0;
          next_state = ST_RUN;
          gpr_wa = pend_rd;
          fpr_wa = pend_rd;
          gpr_we = (pend == LD_GPR);
          gpr_wd = mem_rdata[31:0];
          fpr_we = (pend == LD_FS) || (pend == LD_FD);
          fpr_wd = (pend == LD_FD) ? mem_rdata : pms_s2d(mem_rdata[31:0]);
        end
      end
      default: next_state = ST_RUN;
    endcase
    next_ready = (next_state == ST_RUN);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      pend <= LD_NONE;
      pend_rd <= 5'h00;
      mem_out <= '0;
      issue_ready <= 1'b1;
      exc_taken <= 1'b0;
      fetch_addr <= `PMS_RESET_PC;
      machine_state_register <= `PMS_MSR_RESET;
      condition_register <= 32'h0;
      float_status_control_reg <= 32'h0;
      save_restore_address_reg <= 32'h0;
      save_restore_state_reg <= 32'h0;
      integer_exception_register <= 32'h0;
      tb <= 64'h0;
    end else begin
      state <= next_state;
      pend <= next_pend;
      pend_rd <= next_pend_rd;
      mem_out <= next_mem;
      issue_ready <= next_ready;
      exc_taken <= next_exc;
      fetch_addr <= next_pc;
      machine_state_register <= next_msr;
      condition_register <= next_cr;
      float_status_control_reg <= next_float_status_control_reg;
      save_restore_address_reg <= next_save_restore_address_reg;
      save_restore_state_reg <= next_save_restore_state_reg;
      integer_exception_register <= next_xer;
      tb <= next_tb;
    end
  end

  // register files carry no reset so they map onto plain ram
  always_ff @(posedge ref_clk) begin
    if (gpr_we) begin
      integer_register[gpr_wa] <= gpr_wd;
    end
    if (fpr_we) begin
      float_register[fpr_wa] <= fpr_wd;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_EXC_SUPER: assert property (exc_taken |-> !machine_state_register[`PMS_MSR_PR])
    else $error("exception left user level set");
  AST_EXC_SAVE: assert property (exc_taken |-> save_restore_state_reg == $past(machine_state_register))
    else $error("machine state not saved on exception");
  AST_ONE_EXC: assert property (exc_taken |-> $past(issue_ready) && !mem_out.req)
    else $error("exception not tied to one issued instruction");
  AST_MEM_FIRST: assert property (state == ST_MEM |-> !exc_taken && !issue_ready)
    else $error("exception or issue while access pending");
  AST_ZERO_BASE: assert property (go && op == `PMS_OP_LWZ && ra == 5'h00 && instr[15:0] == 16'h0
    |=> mem_out.req && mem_out.addr == 32'h0)
    else $error("zero base with zero offset not address zero");
  AST_INDEX: assert property (go && op == `PMS_OP_X && (xo == `PMS_XO_LWZX || xo == `PMS_XO_STWX) && ra == 5'h00
    |=> mem_out.addr == $past(index_register_operand))
    else $error("index mode address wrong");
  AST_PRIV: assert property (go && pr && op == `PMS_OP_X && xo == `PMS_XO_MTMSR
    |=> exc_taken && fetch_addr == `PMS_VEC_PROG)
    else $error("user level state write not trapped");
  AST_EMUL: assert property (go && op == `PMS_OP_FPS |=> exc_taken && fetch_addr == `PMS_VEC_EMU)
    else $error("optional op did not take emulation trap");
  AST_SEQ: assert property (go && op == `PMS_OP_ADDI |=> fetch_addr == $past(fetch_addr) + `PMS_INSTR_BYTES)
    else $error("sequential fetch address wrong");
  AST_XER_RSV: assert property ((integer_exception_register & ~`PMS_XER_MASK) == 32'h0)
    else $error("reserved exception register bits set");
  AST_LFD: assert property (state == ST_MEM && mem_ack && pend == LD_FD
    |=> float_register[$past(pend_rd)] == $past(mem_rdata))
    else $error("double load converted");
  COV_TRAP: cover property (go && op == `PMS_OP_SC ##1 exc_taken);
  COV_LOAD: cover property (state == ST_MEM ##[1:8] state == ST_RUN);
  COV_RFI: cover property (go && op == `PMS_OP_19 && xo == `PMS_XO_RFI && !pr);
  COV_CMP: cover property (go && op == `PMS_OP_FPD && xo == `PMS_XO_FCMPU);
endmodule

/* File: verif/cpu_programming_model_state_tb_top.sv */
// self-checking bench for the programming-model state block
`timescale 1ns/1ns
`include "pms_cfg.svh"
module cpu_programming_model_state_tb_top import pms_pkg::*; ;
  logic ref_clk;
  logic rst;
  logic instr_valid;
  logic [31:0] instr;
  logic issue_ready;
  logic [31:0] fetch_addr;
  pms_mem_s mem_out;
  logic mem_ack;
  logic [63:0] mem_rdata;
  logic exc_taken;
  logic [31:0] machine_state_register;
  logic [31:0] condition_register;
  logic [31:0] float_status_control_reg;
  logic [31:0] pc;
  int num_errors;
  int checks_done;

  pms_core DUT (
    .ref_clk(ref_clk),
    .rst(rst),
    .instr_valid(instr_valid),
    .instr(instr),
    .issue_ready(issue_ready),
    .fetch_addr(fetch_addr),
    .mem_out(mem_out),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .exc_taken(exc_taken),
    .machine_state_register(machine_state_register),
    .condition_register(condition_register),
    .float_status_control_reg(float_status_control_reg)
  );

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] d_form(input logic [5:0] op, input logic [4:0] t, input logic [4:0] a,
                                         input logic [15:0] d);
    return {op, t, a, d};
  endfunction

  function automatic logic [31:0] x_form(input logic [5:0] op, input logic [4:0] t, input logic [4:0] a,
                                         input logic [4:0] b, input logic [9:0] xo);
    return {op, t, a, b, xo, 1'b0};
  endfunction

  // special-register number travels with its two halves swapped
  function automatic logic [31:0] spr_op(input logic [9:0] xo, input logic [4:0] r, input logic [9:0] spr);
    return x_form(`PMS_OP_X, r, spr[4:0], spr[9:5], xo);
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks done %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    pc = `PMS_RESET_PC;
    chk(issue_ready, 1'b1);
    chk(fetch_addr, pc);
    chk(machine_state_register, `PMS_MSR_RESET);
    chk({exc_taken, mem_out.req, condition_register}, 0);
  endtask

  // request held from one falling edge through the rising edge that takes it
  task automatic issue(input logic [31:0] ins);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (issue_ready !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 8) num_errors++;
    instr_valid = 1'b1;
    instr = ins;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    instr = ~ins;
  endtask

  task automatic op(input logic [31:0] ins);
    issue(ins);
    chk(exc_taken, 1'b0);
    pc = pc + `PMS_INSTR_BYTES;
    chk(fetch_addr, pc);
  endtask

  // far side answers one cycle late, then drops its data to the inverse
  task automatic mem(input logic [31:0] ins, input logic [63:0] rd, input logic [31:0] ea, input logic [63:0] wd);
    pms_mem_s m;
    int n;
    n = 0;
    issue(ins);
    chk({mem_out.req, issue_ready}, 2'b10);
    @(negedge ref_clk);
    m = mem_out;
    mem_rdata = rd;
    mem_ack = 1'b1;
    @(negedge ref_clk);
    mem_ack = 1'b0;
    mem_rdata = ~rd;
    while (issue_ready !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 8) num_errors++;
    chk(m.addr, ea);
    if (m.we === 1'b1) chk((m.dbl === 1'b1) ? m.wdata : {32'h0, m.wdata[31:0]}, wd);
    chk(mem_out.req, 1'b0);
    pc = pc + `PMS_INSTR_BYTES;
    chk(fetch_addr, pc);
  endtask

  // saved return address is read back through a store of the save register
  task automatic trap(input logic [31:0] ins, input logic [31:0] vec, input logic [31:0] sr0);
    issue(ins);
    chk(exc_taken, 1'b1);
    chk(fetch_addr, vec);
    chk(machine_state_register[`PMS_MSR_PR], 1'b0);
    pc = vec;
    op(spr_op(`PMS_XO_MFSPR, 3, `PMS_SPR_SAVE_RESTORE_ADDRESS_REG));
    mem(d_form(`PMS_OP_STW, 3, 0, 16'h0000), 0, 32'h0, {32'h0, sr0});
  endtask

  task automatic t_int_addr();
    op(d_form(`PMS_OP_ADDI, 1, 0, 16'h0010));
    mem(d_form(`PMS_OP_STW, 1, 1, 16'h0000), 0, 32'h10, 64'h10);
    mem(x_form(`PMS_OP_X, 1, 0, 1, `PMS_XO_STWX), 0, 32'h10, 64'h10);
    mem(x_form(`PMS_OP_X, 7, 1, 1, `PMS_XO_LWZX), 64'hffffffff12345678, 32'h20, 0);
    mem(d_form(`PMS_OP_STW, 7, 0, 16'h0000), 0, 32'h0, 64'h12345678);
    mem(d_form(`PMS_OP_LWZ, 8, 0, 16'h0000), 64'h0000000087654321, 32'h0, 0);
    mem(d_form(`PMS_OP_STW, 8, 1, 16'hfff0), 0, 32'h0, 64'h87654321);
    op(x_form(`PMS_OP_X, 9, 1, 7, `PMS_XO_ADD));
    mem(d_form(`PMS_OP_STW, 9, 0, 16'h0000), 0, 32'h0, 64'h12345688);
    $display("test int_addr done");
  endtask

  task automatic t_xer();
    op(d_form(`PMS_OP_ADDI, 5, 0, 16'hffff));
    op(spr_op(`PMS_XO_MTSPR, 5, `PMS_SPR_XER));
    op(spr_op(`PMS_XO_MFSPR, 6, `PMS_SPR_XER));
    mem(d_form(`PMS_OP_STW, 6, 1, 16'h0004), 0, 32'h14, {32'h0, `PMS_XER_MASK});
    $display("test xer done");
  endtask

  task automatic t_float();
    mem(d_form(`PMS_OP_LFD, 1, 1, 16'h0008), 64'h3ff8000000000000, 32'h18, 0);
    mem(d_form(`PMS_OP_STFS, 1, 1, 16'h000c), 0, 32'h1c, 64'h3fc00000);
    mem(d_form(`PMS_OP_LFS, 2, 1, 16'h0010), 64'h3f800000, 32'h20, 0);
    mem(d_form(`PMS_OP_STFD, 2, 1, 16'h0010), 0, 32'h20, 64'h3ff0000000000000);
    mem(d_form(`PMS_OP_LFD, 3, 1, 16'h0018), 64'h3ff0000000400000, 32'h28, 0);
    mem(d_form(`PMS_OP_STFD, 3, 1, 16'h0018), 0, 32'h28, 64'h3ff0000000400000);
    mem(x_form(`PMS_OP_X, 3, 0, 1, `PMS_XO_STFIWX), 0, 32'h10, 64'h00400000);
    op(x_form(`PMS_OP_FPD, 4, 0, 3, `PMS_XO_FRSP));
    chk(float_status_control_reg[`PMS_FLOAT_STATUS_CONTROL_REG_XX], 1'b1);
    mem(d_form(`PMS_OP_STFD, 4, 1, 16'h0018), 0, 32'h28, 64'h3ff0000000000000);
    op(x_form(`PMS_OP_FPD, 0, 1, 2, `PMS_XO_FCMPU));
    chk(condition_register[31:28], 4'h4);
    chk(float_status_control_reg[15:12], 4'h4);
    $display("test float done");
  endtask

  task automatic t_decode();
    logic [31:0] ok [4];
    ok = '{x_form(`PMS_OP_X, 0, 0, 0, `PMS_XO_SYNC), x_form(`PMS_OP_X, 0, 0, 0, `PMS_XO_EIEIO),
           x_form(`PMS_OP_19, 0, 0, 0, `PMS_XO_ISYNC), spr_op(`PMS_XO_MFTB, 7, 10'h10c)};
    trap(32'hfc00002a, `PMS_VEC_EMU, pc);
    trap(x_form(`PMS_OP_FPS, 5, 2, 2, 10'h015), `PMS_VEC_EMU, pc);
    trap(32'h04000000, `PMS_VEC_PROG, pc);
    foreach (ok[i]) op(ok[i]);
    $display("test decode done");
  endtask

  task automatic t_priv();
    logic [31:0] sr;
    op(d_form(`PMS_OP_ADDI, 10, 0, 16'h00ff));
    op(x_form(`PMS_OP_X, 10, 0, 0, `PMS_XO_MTMSR));
    op(x_form(`PMS_OP_X, 11, 0, 0, `PMS_XO_MFMSR));
    mem(d_form(`PMS_OP_STW, 11, 0, 16'h0000), 0, 32'h0, 64'hf3);
    op(d_form(`PMS_OP_ADDI, 2, 0, 16'h4000));
    op(x_form(`PMS_OP_X, 2, 0, 0, `PMS_XO_MTMSR));
    chk(machine_state_register, 32'h4000);
    op(spr_op(`PMS_XO_MFTB, 7, 10'h10c));
    trap(x_form(`PMS_OP_X, 0, 0, 0, `PMS_XO_MTMSR), `PMS_VEC_PROG, pc);
    op(spr_op(`PMS_XO_MFSPR, 4, `PMS_SPR_SAVE_RESTORE_STATE_REG));
    mem(d_form(`PMS_OP_STW, 4, 0, 16'h0000), 0, 32'h0, 64'h4000);
    op(x_form(`PMS_OP_X, 2, 0, 0, `PMS_XO_MTMSR));
    sr = pc + `PMS_INSTR_BYTES;
    trap(32'h44000002, `PMS_VEC_SC, sr);
    issue(x_form(`PMS_OP_19, 0, 0, 0, `PMS_XO_RFI));
    pc = sr;
    chk(fetch_addr, pc);
    chk({exc_taken, machine_state_register}, 33'h000004000);
    trap(x_form(`PMS_OP_19, 0, 0, 0, `PMS_XO_RFI), `PMS_VEC_PROG, pc);
    $display("test priv done");
  endtask

  task automatic t_branch();
    issue(32'h48000202);
    chk(exc_taken, 1'b0);
    pc = 32'h200;
    chk(fetch_addr, pc);
    $display("test branch done");
  endtask

  // second reset in mid-run: register file contents must survive it
  task automatic t_retain();
    do_reset();
    mem(d_form(`PMS_OP_STW, 6, 0, 16'h0000), 0, 32'h0, {32'h0, `PMS_XER_MASK});
    $display("test retain done");
  endtask

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 32'h0;
    mem_ack = 1'b0;
    mem_rdata = 64'h0;
    num_errors = 0;
    checks_done = 0;
    pc = `PMS_RESET_PC;
    do_reset();
    $display("test reset done");
    t_int_addr();
    t_xer();
    t_float();
    t_decode();
    t_priv();
    t_branch();
    t_retain();
    give_verdict();
  end

  // whole run is a few hundred cycles; this span leaves ample margin
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
